// ===== mfesd_cs_model.sv
// command streamer model: issues descriptor offsets, collects results
`timescale 1ns/1ps
module mfesd_cs_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic go,
    input wire logic [6:0] ofs,
    output logic cmd_valid,
    output logic [6:0] cmd_offset,
    input wire logic desc_valid,
    input wire logic [6:0] desc_offset,
    output logic [6:0] got_ofs,
    output logic [7:0] got_cnt
);
    // one-cycle command; idle offset toggles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_valid <= 1'b0;
            cmd_offset <= 7'h00;
        end else begin
            cmd_valid <= go;
            cmd_offset <= go ? ofs : ~cmd_offset;
        end
    end
    // result capture and count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            got_ofs <= 7'h00;
            got_cnt <= 8'h00;
        end else if (desc_valid) begin
            got_ofs <= desc_offset;
            got_cnt <= got_cnt + 8'h01;
        end
    end
endmodule : mfesd_cs_model

// ===== mfesd_monitor.sv
// checker: port relations of the decoder
`timescale 1ns/1ps
module mfesd_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic cmd_valid,
    input wire logic [6:0] cmd_offset,
    input wire logic desc_valid,
    input wire logic [6:0] desc_offset,
    input wire mfesd_pkg::mfesd_pic_t pic_info,
    input wire mfesd_pkg::mfesd_fectl_t fe_ctl,
    input wire mfesd_pkg::mfesd_sb_t sb_cfg,
    input wire mfesd_pkg::mfesd_kdesc_t kdesc
);
    // one clock domain for every property
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    AST_LAT: assert property (cmd_valid |-> ##2 desc_valid)
        else $error("no result");
    AST_CAUSE: assert property (desc_valid |-> $past(cmd_valid, 2))
        else $error("stray result");
    AST_HI: assert property (cmd_valid && cmd_offset > 7'h0f |-> ##2 desc_offset == $past(cmd_offset, 2))
        else $error("high offset altered");
    AST_FLD: assert property (cmd_valid && pic_info.bsd_sel && (pic_info.top || pic_info.bottom)
        && cmd_offset[6:3] == 4'h1 |-> ##2 desc_offset == $past(cmd_offset, 2))
        else $error("field remapped");
    AST_SB: assert property (!sb_cfg.enable |-> {sb_cfg.nonstall, sb_cfg.mask, sb_cfg.delta_x, sb_cfg.delta_y} == '0)
        else $error("scoreboard field set");
    AST_COD: assert property ($onehot0({pic_info.intra, pic_info.pred, pic_info.bidir}))
        else $error("coding type not one-hot");
    AST_STR: assert property ($onehot0({pic_info.top, pic_info.bottom, pic_info.frame}))
        else $error("structure not one-hot");
    AST_FEOFF: assert property (!fe_ctl.valid |-> fe_ctl == '0)
        else $error("control in wrong mode");
    AST_WO: assert property (!fe_ctl.mv_present && !fe_ctl.subf_rsvd |-> !fe_ctl.wo_present && fe_ctl.wo_dest == 5'h00)
        else $error("weight offset without mv");
    AST_RES: assert property (!fe_ctl.fixed_ofs |-> fe_ctl.resid_src == 8'h00)
        else $error("offset without flag");
    AST_CONST: assert property (kdesc.const_len == 6'h00 |-> !kdesc.const_load && kdesc.const_ofs == 6'h00)
        else $error("offset with zero length");
    AST_GRF: assert property ($past(hresetn) |-> kdesc.grf_blocks inside {[5'h01:5'h10]})
        else $error("block count out of range");
endmodule : mfesd_monitor

bind mfesd_top mfesd_monitor mfesd_monitor_inst (.*);

// ===== mfesd_pkg.sv
// package: register map, fields and carrier types
package mfesd_pkg;

    // register byte offsets on the ahb-lite slave
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_BSD = 8'h04;
    localparam logic [7:0] A_REMAP_LO = 8'h08;
    localparam logic [7:0] A_REMAP_HI = 8'h0c;
    localparam logic [7:0] A_FECTL = 8'h10;
    localparam logic [7:0] A_SBCTL = 8'h14;
    localparam logic [7:0] A_SBD0 = 8'h18;
    localparam logic [7:0] A_SBD1 = 8'h1c;
    localparam logic [7:0] A_KD0 = 8'h20;
    localparam logic [7:0] A_KD1 = 8'h24;
    localparam logic [7:0] A_LAST = 8'h28;
    localparam logic [7:0] A_STAT = 8'h2c;

    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_EXT_BIT = 4;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // front-end mode codes
    localparam logic [3:0] MODE_GENERIC = 4'h0;
    localparam logic [3:0] MODE_BSD = 4'h1;
    localparam logic [3:0] MODE_ADV_MC = 4'h4;
    localparam logic [3:0] MODE_ADV_IT = 4'h7;
    localparam logic [3:0] MODE_ALT_IT = 4'hb;

    // picture word fields
    localparam int PIC_CODING_LSB = 9;
    localparam int PIC_STRUCT_LSB = 12;

    // front-end control fields
    localparam int FC_FIXED_BIT = 26;
    localparam int FC_SUBF_LSB = 24;
    localparam int FC_RSRC_LSB = 16;
    localparam int FC_WO_LSB = 8;
    localparam int FC_RDST_LSB = 0;
    localparam logic [1:0] SUBF_NONE = 2'h0;
    localparam logic [1:0] SUBF_MV = 2'h1;
    localparam logic [1:0] SUBF_RSVD = 2'h2;
    localparam logic [1:0] SUBF_BOTH = 2'h3;

    // scoreboard fields
    localparam int SB_EN_BIT = 31;
    localparam int SB_TYPE_BIT = 30;
    localparam int SB_MASK_LSB = 0;
    localparam int SB_DEPS = 8;

    // kernel descriptor fields
    localparam int KD_START_LSB = 6;
    localparam int KD_GRF_LSB = 0;
    localparam int KD_CLEN_LSB = 26;
    localparam int KD_COFS_LSB = 20;

    // remap table geometry
    localparam int REMAP_ENTRIES = 16;
    localparam int REMAP_HALF = 8;
    localparam logic [6:0] REMAP_MAX_OFS = 7'h0f;

    // picture information
    typedef struct packed {
        logic bsd_sel;  // bitstream decode state in force
        logic intra;    // coding type 01
        logic pred;     // coding type 10
        logic bidir;    // coding type 11
        logic top;      // structure 01
        logic bottom;   // structure 10
        logic frame;    // structure 11
    } mfesd_pic_t;

    // front-end control decode
    typedef struct packed {
        logic valid;            // word is meaningful in this mode
        logic fixed_ofs;        // residual at fixed source offset
        logic mv_present;       // motion vectors may be present
        logic wo_present;       // weight/offset may be present
        logic subf_rsvd;        // reserved presence code seen
        logic [7:0] resid_src;  // residual source offset, dwords
        logic [4:0] wo_dest;    // weight/offset register offset
        logic [4:0] inter_dest; // inter residual register offset
    } mfesd_fectl_t;

    // scoreboard configuration
    typedef struct packed {
        logic enable;              // scoreboard on
        logic nonstall;            // non-stalling type
        logic [7:0] mask;          // effective dependency mask
        logic [7:0][3:0] delta_x;  // signed horizontal deltas
        logic [7:0][3:0] delta_y;  // signed vertical deltas
    } mfesd_sb_t;

    // kernel descriptor decode
    typedef struct packed {
        logic [25:0] start_ptr;  // 64-byte aligned start offset
        logic [4:0] grf_blocks;  // 1..16 blocks of 8 registers
        logic const_load;        // constant entry is loaded
        logic [5:0] const_len;   // read length, 8-dword registers
        logic [5:0] const_ofs;   // read offset, 8-dword units
    } mfesd_kdesc_t;

endpackage : mfesd_pkg

// ===== mfesd_remap_mem.sv
// remap table memory: 16 four-bit entries, two eight-entry word writes, registered read
`timescale 1ns/1ps
module mfesd_remap_mem (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire logic [31:0] wdata,
    input wire logic [3:0] rd_addr,
    output logic [3:0] rd_data
);
    logic [3:0] entry_ff [mfesd_pkg::REMAP_ENTRIES]; // table entries

    // each entry resets to identity and loads from its nibble
    for (genvar i = 0; i < mfesd_pkg::REMAP_ENTRIES; i++) begin : g_ent
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                entry_ff[i] <= 4'(i);
            end else if (i < mfesd_pkg::REMAP_HALF ? wr_lo : wr_hi) begin
                entry_ff[i] <= wdata[4*(i % mfesd_pkg::REMAP_HALF) +: 4];
            end
        end
    end

    // read data leaves from a register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_data <= 4'h0;
        end else begin
            rd_data <= entry_ff[rd_addr];
        end
    end
endmodule : mfesd_remap_mem

// ===== mfesd_top.sv
// media front-end state decoder: ahb-lite registers, remap pipeline, decoded state
//
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - coding type 01 intra, 10 predictive, 11 bidirectional
// - remap word one holds entries 0..7
// - remap word two holds entries 8..15
// - offsets above 15 pass unchanged
// - remap only when extended state selected
// - entries 0..7 serve frame and field destinations
// - entries 8..15 ignored for field destinations in bitstream decode state
// - scoreboard enable gates all scoreboard fields
// - scoreboard type 0 stalling, 1 non-stalling
// - mask bit n enables dependency n
// - dependency 3 deltas: y top, x next nibble
// - other deltas in successive bytes of words
// - control word only in advanced transform/mc modes
// - fixed offset flag places residual at offset
// - presence code 00 none, 01 mv, 11 both
// - weight/offset offset ignored with presence code 00
// - inter residual at offset, intra at start
// - kernel start pointer from upper 26 bits
// - register blocks decode as value plus one
// - zero read length loads nothing, ignores offset
// - read offset in eight-dword units 0..63
// - mode 0001 with extended enable selects bitstream decode state
// - structure 01 top, 10 bottom, 11 frame
module mfesd_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic cmd_valid,
    input wire logic [6:0] cmd_offset,
    output logic desc_valid,
    output logic [6:0] desc_offset,
    output mfesd_pkg::mfesd_pic_t pic_info,
    output mfesd_pkg::mfesd_fectl_t fe_ctl,
    output mfesd_pkg::mfesd_sb_t sb_cfg,
    output mfesd_pkg::mfesd_kdesc_t kdesc
);

    // two-bit code to one-hot {11,10,01}; 00 gives none
    function automatic logic [2:0] code3(input logic [1:0] c);
        logic [2:0] r;
        r = 3'h0;
        unique case (c)
            2'h1: r = 3'h1;
            2'h2: r = 3'h2;
            2'h3: r = 3'h4;
            2'h0: r = 3'h0;
        endcase
        return r;
    endfunction : code3

    // bus phase registers
    logic dph_wr_ff;        // data phase of a write pending
    logic [7:0] dph_addr_ff; // latched byte address
    logic [31:0] hrdata_ff; // read data for the data phase
    logic [31:0] nxt_hrdata;
    logic aph_take;         // address phase accepted

    // state registers written by software
    logic [31:0] ctrl_ff;   // mode and extended enable
    logic [31:0] bsd_ff;    // picture word
    logic [31:0] fectl_ff;  // front-end control
    logic [31:0] sbctl_ff;  // scoreboard control
    logic [31:0] sbd0_ff;   // deltas 0..3
    logic [31:0] sbd1_ff;   // deltas 4..7
    logic [31:0] kd0_ff;    // descriptor word 0
    logic [31:0] kd1_ff;    // descriptor word 1

    // remap pipeline
    logic s1_vld_ff;        // lookup in flight
    logic [6:0] s1_ofs_ff;  // raw offset in flight
    logic s1_apply_ff;      // table result to be used
    logic nxt_apply;
    logic [3:0] rd_entry;   // table read data
    logic desc_valid_ff;
    logic [6:0] desc_offset_ff;

    // decoded views of the state
    logic [3:0] mode;
    logic ext_en;
    logic bsd_sel;
    logic is_field;
    logic adv_mode;
    logic wr_lo;
    logic wr_hi;
    logic [2:0] ctype_oh;
    logic [2:0] pstruct_oh;

    mfesd_pkg::mfesd_pic_t pic_ff;
    mfesd_pkg::mfesd_fectl_t fectl_dec_ff;
    mfesd_pkg::mfesd_sb_t sb_ff;
    mfesd_pkg::mfesd_kdesc_t kd_ff;

    // zero-wait slave, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;

    // an address phase is taken on a non-idle selected transfer
    assign aph_take = hsel && hready && htrans[1];

    // mode and selection terms
    assign mode = ctrl_ff[mfesd_pkg::CTRL_MODE_LSB +: 4];
    assign ext_en = ctrl_ff[mfesd_pkg::CTRL_EXT_BIT];
    assign bsd_sel = ext_en && (mode == mfesd_pkg::MODE_BSD);
    assign adv_mode = (mode == mfesd_pkg::MODE_ADV_MC)
                   || (mode == mfesd_pkg::MODE_ADV_IT);
    assign ctype_oh = code3(bsd_ff[mfesd_pkg::PIC_CODING_LSB +: 2]);
    assign pstruct_oh = code3(bsd_ff[mfesd_pkg::PIC_STRUCT_LSB +: 2]);
    assign is_field = pstruct_oh[0] || pstruct_oh[1];

    // table writes happen in the write data phase
    assign wr_lo = dph_wr_ff && (dph_addr_ff == mfesd_pkg::A_REMAP_LO);
    assign wr_hi = dph_wr_ff && (dph_addr_ff == mfesd_pkg::A_REMAP_HI);

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr_ff <= 1'b0;
            dph_addr_ff <= 8'h00;
        end else if (hready) begin
            dph_wr_ff <= aph_take && hwrite;
            dph_addr_ff <= {haddr[7:2], 2'b00};
        end
    end

    // read mux; unmapped and write-only words read zero
    always_comb begin
        nxt_hrdata = 32'h0000_0000;
        unique case ({haddr[7:2], 2'b00})
            mfesd_pkg::A_CTRL: nxt_hrdata = ctrl_ff;
            mfesd_pkg::A_BSD: nxt_hrdata = bsd_ff;
            mfesd_pkg::A_FECTL: nxt_hrdata = fectl_ff;
            mfesd_pkg::A_SBCTL: nxt_hrdata = sbctl_ff;
            mfesd_pkg::A_SBD0: nxt_hrdata = sbd0_ff;
            mfesd_pkg::A_SBD1: nxt_hrdata = sbd1_ff;
            mfesd_pkg::A_KD0: nxt_hrdata = kd0_ff;
            mfesd_pkg::A_KD1: nxt_hrdata = kd1_ff;
            mfesd_pkg::A_LAST: nxt_hrdata = {25'h0, desc_offset_ff};
            mfesd_pkg::A_STAT: nxt_hrdata = {19'h0, kd_ff.const_load,
                                             sb_ff.enable, fectl_dec_ff.valid,
                                             bsd_sel, 2'h0, pstruct_oh,
                                             1'b0, ctype_oh};
            default: nxt_hrdata = 32'h0000_0000;
        endcase
    end

    // read data latched at the address phase edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (aph_take && !hwrite) begin
            hrdata_ff <= nxt_hrdata;
        end
    end

    // mode and extended-state control
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= mfesd_pkg::CTRL_RST;
        end else if (dph_wr_ff && dph_addr_ff == mfesd_pkg::A_CTRL) begin
            ctrl_ff <= {27'h0, hwdata[mfesd_pkg::CTRL_EXT_BIT:0]};
        end
    end

    // extended state words
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bsd_ff <= 32'h0000_0000;
            fectl_ff <= 32'h0000_0000;
            sbctl_ff <= 32'h0000_0000;
            sbd0_ff <= 32'h0000_0000;
            sbd1_ff <= 32'h0000_0000;
        end else if (dph_wr_ff) begin
            unique case (dph_addr_ff)
                mfesd_pkg::A_BSD: bsd_ff <= hwdata;
                mfesd_pkg::A_FECTL: fectl_ff <= hwdata;
                mfesd_pkg::A_SBCTL: sbctl_ff <= hwdata;
                mfesd_pkg::A_SBD0: sbd0_ff <= hwdata;
                mfesd_pkg::A_SBD1: sbd1_ff <= hwdata;
                default: ;
            endcase
        end
    end

    // kernel descriptor words
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            kd0_ff <= 32'h0000_0000;
            kd1_ff <= 32'h0000_0000;
        end else if (dph_wr_ff) begin
            if (dph_addr_ff == mfesd_pkg::A_KD0) begin
                kd0_ff <= hwdata;
            end
            if (dph_addr_ff == mfesd_pkg::A_KD1) begin
                kd1_ff <= hwdata;
            end
        end
    end

    // remap table, read address from the command
    mfesd_remap_mem u_mem (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_lo(wr_lo),
        .wr_hi(wr_hi),
        .wdata(hwdata),
        .rd_addr(cmd_offset[3:0]),
        .rd_data(rd_entry)
    );

    // decide whether the table answer replaces the offset
    always_comb begin
        nxt_apply = ext_en;
        if (cmd_offset > mfesd_pkg::REMAP_MAX_OFS) begin
            nxt_apply = 1'b0;
        end else if (bsd_sel && is_field && cmd_offset[3]) begin
            nxt_apply = 1'b0;
        end
        // low entries apply to frame and field alike
    end

    // stage one: table read in flight
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_vld_ff <= 1'b0;
            s1_ofs_ff <= 7'h00;
            s1_apply_ff <= 1'b0;
        end else begin
            s1_vld_ff <= cmd_valid;
            s1_ofs_ff <= cmd_offset;
            s1_apply_ff <= cmd_valid && nxt_apply;
        end
    end

    // stage two: registered descriptor offset toward spawning
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            desc_valid_ff <= 1'b0;
            desc_offset_ff <= 7'h00;
        end else begin
            desc_valid_ff <= s1_vld_ff;
            if (s1_vld_ff) begin
                desc_offset_ff <= s1_apply_ff ? {3'h0, rd_entry} : s1_ofs_ff;
            end
        end
    end

    assign desc_valid = desc_valid_ff;
    assign desc_offset = desc_offset_ff;

    // picture information decode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pic_ff <= '0;
        end else begin
            pic_ff.bsd_sel <= bsd_sel;
            pic_ff.intra <= ctype_oh[0];
            pic_ff.pred <= ctype_oh[1];
            pic_ff.bidir <= ctype_oh[2];
            pic_ff.top <= pstruct_oh[0];
            pic_ff.bottom <= pstruct_oh[1];
            pic_ff.frame <= pstruct_oh[2];
        end
    end

    // front-end control decode; zero outside the advanced modes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fectl_dec_ff <= '0;
        end else if (!(ext_en && adv_mode)) begin
            fectl_dec_ff <= '0;
        end else begin
            fectl_dec_ff.valid <= 1'b1;
            fectl_dec_ff.fixed_ofs <= fectl_ff[mfesd_pkg::FC_FIXED_BIT];
            fectl_dec_ff.mv_present <=
                fectl_ff[mfesd_pkg::FC_SUBF_LSB +: 2] == mfesd_pkg::SUBF_MV
                || fectl_ff[mfesd_pkg::FC_SUBF_LSB +: 2] == mfesd_pkg::SUBF_BOTH;
            fectl_dec_ff.wo_present <=
                fectl_ff[mfesd_pkg::FC_SUBF_LSB +: 2] == mfesd_pkg::SUBF_BOTH;
            fectl_dec_ff.subf_rsvd <=
                fectl_ff[mfesd_pkg::FC_SUBF_LSB +: 2] == mfesd_pkg::SUBF_RSVD;
            // offset used only with the fixed flag
            fectl_dec_ff.resid_src <= fectl_ff[mfesd_pkg::FC_FIXED_BIT]
                ? fectl_ff[mfesd_pkg::FC_RSRC_LSB +: 8] : 8'h00;
            // presence code 00: weight/offset offset dropped
            fectl_dec_ff.wo_dest <=
                fectl_ff[mfesd_pkg::FC_SUBF_LSB +: 2] == mfesd_pkg::SUBF_NONE
                ? 5'h00 : fectl_ff[mfesd_pkg::FC_WO_LSB +: 5];
            // inter offset; intra residual lands at register 0
            fectl_dec_ff.inter_dest <= fectl_ff[mfesd_pkg::FC_RDST_LSB +: 5];
        end
    end

    // scoreboard control; disabled clears every other field
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sb_ff.enable <= 1'b0;
            sb_ff.nonstall <= 1'b0;
            sb_ff.mask <= 8'h00;
        end else begin
            sb_ff.enable <= sbctl_ff[mfesd_pkg::SB_EN_BIT];
            sb_ff.nonstall <= sbctl_ff[mfesd_pkg::SB_EN_BIT]
                && sbctl_ff[mfesd_pkg::SB_TYPE_BIT];
            sb_ff.mask <= sbctl_ff[mfesd_pkg::SB_EN_BIT]
                ? sbctl_ff[mfesd_pkg::SB_MASK_LSB +: 8] : 8'h00;
        end
    end

    // per-dependency deltas: y in upper nibble, x in lower
    for (genvar d = 0; d < mfesd_pkg::SB_DEPS; d++) begin : g_dep
        logic [7:0] dbyte;
        assign dbyte = (d < 4) ? sbd0_ff[8*(d % 4) +: 8]
                               : sbd1_ff[8*(d % 4) +: 8];
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                sb_ff.delta_x[d] <= 4'h0;
                sb_ff.delta_y[d] <= 4'h0;
            end else if (!sbctl_ff[mfesd_pkg::SB_EN_BIT]) begin
                sb_ff.delta_x[d] <= 4'h0;
                sb_ff.delta_y[d] <= 4'h0;
            end else begin
                sb_ff.delta_y[d] <= dbyte[7:4];
                sb_ff.delta_x[d] <= dbyte[3:0];
            end
        end
    end

    // kernel descriptor decode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            kd_ff <= '0;
        end else begin
            kd_ff.start_ptr <= kd0_ff[31:mfesd_pkg::KD_START_LSB];
            kd_ff.grf_blocks <= {1'b0, kd0_ff[mfesd_pkg::KD_GRF_LSB +: 4]}
                + 5'h01;
            kd_ff.const_len <= kd1_ff[mfesd_pkg::KD_CLEN_LSB +: 6];
            kd_ff.const_load <= kd1_ff[mfesd_pkg::KD_CLEN_LSB +: 6] != 6'h00;
            // zero length makes the offset irrelevant
            kd_ff.const_ofs <= kd1_ff[mfesd_pkg::KD_CLEN_LSB +: 6] == 6'h00
                ? 6'h00 : kd1_ff[mfesd_pkg::KD_COFS_LSB +: 6];
        end
    end

    // decoded structs leave from flip-flops
    assign pic_info = pic_ff;
    assign fe_ctl = fectl_dec_ff;
    assign sb_cfg = sb_ff;
    assign kdesc = kd_ff;

endmodule : mfesd_top

// ===== tb_top.sv
// testbench: bus and command traffic for the decoder
`timescale 1ns/1ps
module tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic go = 1'b0;
    logic [6:0] ofs = 7'h00;
    wire logic hreadyout, hresp, cmd_valid, desc_valid;
    wire logic [31:0] hrdata;
    wire logic [6:0] cmd_offset, desc_offset, got_ofs;
    wire logic [7:0] got_cnt;
    mfesd_pkg::mfesd_pic_t pic_info;
    mfesd_pkg::mfesd_fectl_t fe_ctl;
    mfesd_pkg::mfesd_sb_t sb_cfg;
    mfesd_pkg::mfesd_kdesc_t kdesc;
    int bad_count = 0;
    int n_tests = 0;
    int seed = 29067;
    int cyc = 0;
    logic [63:0] tbl; // remap table image
    logic [31:0] w, r, x;
    logic [6:0] o;
    logic [3:0] md [5];
    logic v;
    always #5 hclk = ~hclk;
    mfesd_top mfesd_top_inst (.*, .hready(hreadyout));
    mfesd_cs_model mfesd_cs_model_inst (.*);
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    // hang guard
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    // one word transfer, then settle
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
        repeat (2) @(posedge hclk);
    endtask : bus
    task automatic send(input logic [6:0] c, input logic [6:0] exp);
        logic [7:0] c0;
        c0 = got_cnt;
        go <= 1'b1;
        ofs <= c;
        @(posedge hclk);
        go <= 1'b0;
        repeat (4) @(posedge hclk);
        chk("result count", 32'(c0 + 8'h01), 32'(got_cnt));
        chk("desc_offset", 32'(exp), 32'(got_ofs));
    endtask : send
    // expected lookup
    function automatic logic [6:0] remap(input logic [6:0] c, input logic ext, input logic fld);
        if (!ext || c > 7'h0f || (fld && c[3])) return c;
        return {3'h0, tbl[c[3:0] * 4 +: 4]};
    endfunction : remap
    initial begin
        md = '{4'h0, 4'h1, 4'h4, 4'h7, 4'hb};
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(mfesd_pkg::A_CTRL, 1'b0, 32'h0);
        chk("ctrl", 32'h0, r);
        chk("grf", 32'h1, 32'(kdesc.grf_blocks));
        bus(8'h3c, 1'b1, 32'hffff_ffff);
        bus(8'h3c, 1'b0, 32'h0);
        chk("unmapped", 32'h0, r);
        $display("test reset done");
        tbl = {$random(seed), $random(seed)};
        bus(mfesd_pkg::A_REMAP_LO, 1'b1, tbl[31:0]);
        bus(mfesd_pkg::A_REMAP_HI, 1'b1, tbl[63:32]);
        for (int e = 0; e < 2; e++) begin
            bus(mfesd_pkg::A_CTRL, 1'b1, {27'h0, e[0], 4'h0});
            chk("bsd_sel", 32'h0, 32'(pic_info.bsd_sel));
            for (int i = 0; i < 20; i++) begin
                o = (i < 16) ? 7'(i) : (i == 16) ? 7'h10 : 7'($random(seed)) | 7'h10;
                send(o, remap(o, e[0], 1'b0));
            end
        end
        bus(mfesd_pkg::A_LAST, 1'b0, 32'h0);
        chk("last", 32'(remap(o, 1'b1, 1'b0)), r);
        bus(mfesd_pkg::A_CTRL, 1'b1, 32'h11);
        chk("bsd_sel", 32'h1, 32'(pic_info.bsd_sel));
        for (int s = 0; s < 4; s++) begin
            w = $random(seed);
            w[13:9] = {s[1:0], 1'b0, s[1:0]};
            bus(mfesd_pkg::A_BSD, 1'b1, w);
            x = (s == 0) ? 32'h0 : 32'h1 << (s - 1);
            chk("coding", x, 32'({pic_info.bidir, pic_info.pred, pic_info.intra}));
            chk("struct", x, 32'({pic_info.frame, pic_info.bottom, pic_info.top}));
            v = (s == 1 || s == 2);
            for (int i = 0; i < 16; i++) send(7'(i), remap(7'(i), 1'b1, v));
        end
        $display("test remap done");
        for (int k = 0; k < 5; k++) begin
            for (int p = 0; p < 4; p++) begin
                bus(mfesd_pkg::A_CTRL, 1'b1, {28'h1, md[k]});
                w = $random(seed) & 32'h07f8_1f1f;
                w[26] = w[26] | (md[k] == 4'h4);
                w[25:24] = p[1:0];
                if (!w[26]) w[23:16] = 8'h00;
                if (p == 0) w[12:0] = 13'h0;
                bus(mfesd_pkg::A_FECTL, 1'b1, w);
                v = (md[k] == 4'h4 || md[k] == 4'h7);
                x = {9'h0, 1'b1, w[26], p[0], p == 3, p == 2, w[23:16], w[12:8], w[4:0]};
                if (p != 2) chk("fe_ctl", v ? x : 32'h0, 32'(fe_ctl));
                else chk("reserved code", 32'(v), 32'(fe_ctl.subf_rsvd));
            end
        end
        for (int t = 0; t < 3; t++) begin
            w = $random(seed) & 32'h0000_00ff;
            w[31:30] = {t != 0, t == 2};
            tbl = {$random(seed), $random(seed)};
            bus(mfesd_pkg::A_SBCTL, 1'b1, w);
            bus(mfesd_pkg::A_SBD0, 1'b1, tbl[31:0]);
            bus(mfesd_pkg::A_SBD1, 1'b1, tbl[63:32]);
            x = w[31] ? {22'h0, w[31:30], w[7:0]} : 32'h0;
            chk("sb_ctl", x, 32'({sb_cfg.enable, sb_cfg.nonstall, sb_cfg.mask}));
            for (int d = 0; d < 8; d++) begin
                x = w[31] ? 32'(tbl[d * 8 +: 8]) : 32'h0;
                chk("delta", x, 32'({sb_cfg.delta_y[d], sb_cfg.delta_x[d]}));
            end
        end
        for (int t = 0; t < 4; t++) begin
            w = $random(seed) & 32'hffff_ffce;
            bus(mfesd_pkg::A_KD0, 1'b1, w);
            chk("start", 32'(w[31:6]), 32'(kdesc.start_ptr));
            chk("blocks", 32'(w[3:0]) + 32'h1, 32'(kdesc.grf_blocks));
            w = $random(seed);
            if (t == 0) w[31:26] = 6'h00;
            if (t == 1) w[31:20] = 12'hfff;
            bus(mfesd_pkg::A_KD1, 1'b1, w);
            x = (w[31:26] == 6'h00) ? 32'h0 : {19'h0, 1'b1, w[31:20]};
            chk("const", x, 32'({kdesc.const_load, kdesc.const_len, kdesc.const_ofs}));
        end
        $display("test decode done");
        report_and_stop();
    end
endmodule : tb_top
